// ---- hdl/pbm_pkg.sv ----
// Shared constants and types for the bus master port, device and host ends
package pbm_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_HOLD_US = 100;
    localparam int RST_HOLD_CYC = (RST_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PME_PULSE_NS = 1000;
    localparam int PME_PULSE_CYC = (PME_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Widths
    localparam int AD_W = 32;
    localparam int EVT_W = 8;
    localparam int CTRL_W = 32;
    localparam int RST_CNT_W = 12;
    localparam int PME_CNT_W = 8;

    // ==========================================================
    // Power wake control register fields
    localparam int WAKE_ON_LAN_ENABLE_BIT = 18;
    localparam int LAN_WAKE_SIGNAL_SELECT_BIT = 17;

    // ==========================================================
    // Bus idle level (pulled-up lines)
    localparam logic [AD_W-1:0] AD_IDLE = 32'hFFFF_FFFF;

    // ==========================================================
    // Bus master sequencer states
    typedef enum logic [1:0] {
        PBM_IDLE = 2'b00,
        PBM_REQ = 2'b01,
        PBM_ADDR = 2'b10,
        PBM_DATA = 2'b11
    } pbm_mst_state_t;

endpackage

// ---- hdl/pbm_if.sv ----
// Link interface joining the device end and the host end
`timescale 1ns/100ps
interface pbm_if;
    // Host driven
    logic rst_n;
    logic gnt_n;
    logic [pbm_pkg::AD_W-1:0] ad_host;
    logic ad_host_oe_n;
    // Device driven
    logic inta_out;
    logic inta_oe_n;
    logic pme_out;
    logic pme_oe_n;
    logic req_out;
    logic req_oe_n;
    logic [pbm_pkg::AD_W-1:0] ad_dev;
    logic ad_dev_oe_n;
    logic addr_ph_out;
    logic wr_out;
    logic ctl_oe_n;
    // Resolved wire levels, undriven lines float high
    logic inta_n;
    logic pme_n;
    logic req_n;
    logic addr_ph_n;
    logic wr_n;
    logic [pbm_pkg::AD_W-1:0] ad;

    assign inta_n = inta_oe_n ? 1'b1 : inta_out;
    assign pme_n = pme_oe_n ? 1'b1 : pme_out;
    assign req_n = req_oe_n ? 1'b1 : req_out;
    assign addr_ph_n = ctl_oe_n ? 1'b1 : addr_ph_out;
    assign wr_n = ctl_oe_n ? 1'b1 : wr_out;
    assign ad = !ad_dev_oe_n ? ad_dev : (!ad_host_oe_n ? ad_host : pbm_pkg::AD_IDLE);

    modport dev (
        input rst_n, gnt_n, ad,
        output inta_out, inta_oe_n, pme_out, pme_oe_n, req_out, req_oe_n,
        output ad_dev, ad_dev_oe_n, addr_ph_out, wr_out, ctl_oe_n
    );
    modport host (
        input inta_n, pme_n, req_n, addr_ph_n, wr_n, ad,
        output rst_n, gnt_n, ad_host, ad_host_oe_n
    );
endinterface

// ---- hdl/pbm_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pbm_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                sync_o <= s3_r;
            end
        end
    end
endmodule // pbm_sync

// ---- hdl/pbm_device.sv ----
// Device end: interrupt, wake event and bus master access toward the host
`timescale 1ns/100ps
module pbm_device #(
    parameter int EVT_W = pbm_pkg::EVT_W,
    parameter int PME_PULSE_CYC = pbm_pkg::PME_PULSE_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    pbm_if.dev bus,
    input wire logic [EVT_W-1:0] EVENT_I,
    input wire logic [EVT_W-1:0] EVENT_MASK_I,
    input wire logic [EVT_W-1:0] EVENT_CLEAR_I,
    output logic [EVT_W-1:0] EVENT_FLAGS_O,
    input wire logic [pbm_pkg::CTRL_W-1:0] POWER_WAKE_CONTROL_REGISTER_I,
    input wire logic MAGIC_PKT_I,
    input wire logic PME_STATUS_CLEAR_I,
    output logic PME_STATUS_O,
    input wire logic XFER_REQ_I,
    input wire logic XFER_WRITE_I,
    input wire logic [pbm_pkg::AD_W-1:0] XFER_ADDR_I,
    input wire logic [pbm_pkg::AD_W-1:0] XFER_WDATA_I,
    output logic XFER_BUSY_O,
    output logic XFER_DONE_O,
    output logic [pbm_pkg::AD_W-1:0] XFER_RDATA_O
);
    // ==========================================================
    // Reset: local reset or the link reset pin
    logic link_rst;
    assign link_rst = RESET_I | ~bus.rst_n;

    // ==========================================================
    // Interrupt event flags
    logic [EVT_W-1:0] flags_r;
    logic [EVT_W-1:0] flags_nxt;
    logic irq_pend;
    // Set wins over clear so no event is lost
    assign flags_nxt = (flags_r & ~EVENT_CLEAR_I) | EVENT_I;
    assign irq_pend = |(flags_r & EVENT_MASK_I);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end
    assign EVENT_FLAGS_O = flags_r;

    // ==========================================================
    // Wake on LAN
    localparam int PME_CNT_W = pbm_pkg::PME_CNT_W;
    localparam logic [PME_CNT_W-1:0] PME_LOAD = PME_CNT_W'(PME_PULSE_CYC);
    logic mp_sync;
    logic mp_d_r;
    logic wol_en;
    logic wake_sel;
    logic magic_evt;
    logic pme_status_r;
    logic [PME_CNT_W-1:0] pme_cnt_r;
    logic [PME_CNT_W-1:0] pme_cnt_nxt;
    logic pme_drive;

    // Network side is another clock domain
    pbm_sync pbm_sync_inst (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .async_i(MAGIC_PKT_I),
        .sync_o(mp_sync)
    );

    assign wol_en = POWER_WAKE_CONTROL_REGISTER_I[pbm_pkg::WAKE_ON_LAN_ENABLE_BIT];
    assign wake_sel = POWER_WAKE_CONTROL_REGISTER_I[pbm_pkg::LAN_WAKE_SIGNAL_SELECT_BIT];
    assign magic_evt = wol_en & mp_sync & ~mp_d_r;
    assign pme_cnt_nxt = magic_evt ? PME_LOAD : ((pme_cnt_r != '0) ? pme_cnt_r - 1'b1 : pme_cnt_r);
    // Set: level convention holds until cleared; clear: fixed-width pulse
    assign pme_drive = wol_en & (wake_sel ? pme_status_r : (pme_cnt_r != '0));

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            mp_d_r <= 1'b0;
            pme_status_r <= 1'b0;
            pme_cnt_r <= '0;
        end else begin
            mp_d_r <= mp_sync;
            pme_status_r <= (pme_status_r & ~PME_STATUS_CLEAR_I) | magic_evt;
            pme_cnt_r <= pme_cnt_nxt;
        end
    end
    assign PME_STATUS_O = pme_status_r;

    // ==========================================================
    // Bus master sequencer
    pbm_pkg::pbm_mst_state_t state_r;
    pbm_pkg::pbm_mst_state_t state_nxt;
    logic [pbm_pkg::AD_W-1:0] addr_r;
    logic [pbm_pkg::AD_W-1:0] wdata_r;
    logic wr_r;
    logic take;

    assign take = (state_r == pbm_pkg::PBM_IDLE) & XFER_REQ_I;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pbm_pkg::PBM_IDLE: begin
                if (XFER_REQ_I) begin
                    state_nxt = pbm_pkg::PBM_REQ;
                end
            end
            pbm_pkg::PBM_REQ: begin
                if (!bus.gnt_n) begin
                    state_nxt = pbm_pkg::PBM_ADDR;
                end
            end
            pbm_pkg::PBM_ADDR: begin
                state_nxt = pbm_pkg::PBM_DATA;
            end
            pbm_pkg::PBM_DATA: begin
                state_nxt = pbm_pkg::PBM_IDLE;
            end
            default: begin
                state_nxt = pbm_pkg::PBM_IDLE;
            end
        endcase
    end

    // Next values of the pin drivers
    logic [pbm_pkg::AD_W-1:0] addr_nxt;
    logic wr_nxt;
    logic nxt_req;
    logic nxt_addr;
    logic nxt_data;
    logic ad_oe_n_nxt;
    logic [pbm_pkg::AD_W-1:0] ad_nxt;

    assign addr_nxt = take ? XFER_ADDR_I : addr_r;
    assign wr_nxt = take ? XFER_WRITE_I : wr_r;
    assign nxt_req = state_nxt == pbm_pkg::PBM_REQ;
    assign nxt_addr = state_nxt == pbm_pkg::PBM_ADDR;
    assign nxt_data = state_nxt == pbm_pkg::PBM_DATA;
    // Lines released during a read data phase so the host can drive them
    assign ad_oe_n_nxt = ~(nxt_addr | (nxt_data & wr_nxt));
    assign ad_nxt = nxt_addr ? addr_nxt : wdata_r;

    always_ff @(posedge SYS_CLK_I) begin
        if (link_rst) begin
            state_r <= pbm_pkg::PBM_IDLE;
            addr_r <= '0;
            wdata_r <= '0;
            wr_r <= 1'b0;
            XFER_BUSY_O <= 1'b0;
            XFER_DONE_O <= 1'b0;
            XFER_RDATA_O <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            if (take) begin
                wdata_r <= XFER_WDATA_I;
            end
            XFER_BUSY_O <= state_nxt != pbm_pkg::PBM_IDLE;
            XFER_DONE_O <= state_r == pbm_pkg::PBM_DATA;
            if (state_r == pbm_pkg::PBM_DATA && !wr_r) begin
                XFER_RDATA_O <= bus.ad;
            end
        end
    end

    // ==========================================================
    // Pin drivers, all released under link reset
    always_ff @(posedge SYS_CLK_I) begin
        if (link_rst) begin
            bus.inta_oe_n <= 1'b1;
            bus.pme_oe_n <= 1'b1;
            bus.req_out <= 1'b1;
            bus.req_oe_n <= 1'b1;
            bus.ad_dev <= pbm_pkg::AD_IDLE;
            bus.ad_dev_oe_n <= 1'b1;
            bus.addr_ph_out <= 1'b1;
            bus.wr_out <= 1'b1;
            bus.ctl_oe_n <= 1'b1;
        end else begin
            bus.inta_oe_n <= ~irq_pend;
            bus.pme_oe_n <= ~pme_drive;
            bus.req_out <= ~nxt_req;
            bus.req_oe_n <= 1'b0;
            bus.ad_dev <= ad_nxt;
            bus.ad_dev_oe_n <= ad_oe_n_nxt;
            bus.addr_ph_out <= ~nxt_addr;
            bus.wr_out <= ~wr_nxt;
            bus.ctl_oe_n <= ~(nxt_addr | nxt_data);
        end
    end

    // Open-drain pins only ever pull low
    assign bus.inta_out = 1'b0;
    assign bus.pme_out = 1'b0;
endmodule // pbm_device

// ---- hdl/pbm_host.sv ----
// Host end: reset generator, arbiter and target for the device's accesses
`timescale 1ns/100ps
module pbm_host #(
    parameter int RST_HOLD_CYC = pbm_pkg::RST_HOLD_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    pbm_if.host bus,
    input wire logic HOST_RESET_REQ_I,
    input wire logic GRANT_ENABLE_I,
    input wire logic [pbm_pkg::AD_W-1:0] HOST_RDATA_I,
    output logic LINK_RESET_ACTIVE_O,
    output logic IRQ_O,
    output logic PME_O,
    output logic RD_STROBE_O,
    output logic [pbm_pkg::AD_W-1:0] RD_ADDR_O,
    output logic WR_STROBE_O,
    output logic [pbm_pkg::AD_W-1:0] WR_ADDR_O,
    output logic [pbm_pkg::AD_W-1:0] WR_DATA_O
);
    localparam int RW = pbm_pkg::RST_CNT_W;
    localparam logic [RW-1:0] RST_LOAD = RW'(RST_HOLD_CYC);

    // ==========================================================
    // Link reset held for the minimum time
    logic [RW-1:0] rst_cnt_r;
    logic [RW-1:0] rst_cnt_nxt;
    logic start_rst;
    assign start_rst = RESET_I | HOST_RESET_REQ_I;
    assign rst_cnt_nxt = start_rst ? RST_LOAD : ((rst_cnt_r != '0) ? rst_cnt_r - 1'b1 : rst_cnt_r);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            rst_cnt_r <= RST_LOAD;
            bus.rst_n <= 1'b0;
            LINK_RESET_ACTIVE_O <= 1'b1;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            bus.rst_n <= rst_cnt_nxt == '0;
            LINK_RESET_ACTIVE_O <= rst_cnt_nxt != '0;
        end
    end

    // ==========================================================
    // Arbiter and target
    logic addr_seen;
    logic wr_pend_r;
    logic [pbm_pkg::AD_W-1:0] waddr_r;
    assign addr_seen = bus.rst_n & ~bus.addr_ph_n;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || !bus.rst_n) begin
            bus.gnt_n <= 1'b1;
            bus.ad_host <= pbm_pkg::AD_IDLE;
            bus.ad_host_oe_n <= 1'b1;
            wr_pend_r <= 1'b0;
            waddr_r <= '0;
            IRQ_O <= 1'b0;
            PME_O <= 1'b0;
            RD_STROBE_O <= 1'b0;
            RD_ADDR_O <= '0;
            WR_STROBE_O <= 1'b0;
            WR_ADDR_O <= '0;
            WR_DATA_O <= '0;
        end else begin
            bus.gnt_n <= ~(GRANT_ENABLE_I & ~bus.req_n);
            IRQ_O <= ~bus.inta_n;
            PME_O <= ~bus.pme_n;
            // Read: answer in the data phase right after the address
            bus.ad_host_oe_n <= ~(addr_seen & bus.wr_n);
            bus.ad_host <= HOST_RDATA_I;
            RD_STROBE_O <= addr_seen & bus.wr_n;
            if (addr_seen) begin
                RD_ADDR_O <= bus.ad;
                waddr_r <= bus.ad;
            end
            wr_pend_r <= addr_seen & ~bus.wr_n;
            WR_STROBE_O <= wr_pend_r;
            if (wr_pend_r) begin
                WR_ADDR_O <= waddr_r;
                WR_DATA_O <= bus.ad;
            end
        end
    end
endmodule // pbm_host

// ---- sim/pbm_sva.sv ----
// Link checks between the device end and the host end
`timescale 1ns/100ps
module pbm_sva (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic rst_n,
    input wire logic gnt_n,
    input wire logic ad_host_oe_n,
    input wire logic inta_out,
    input wire logic inta_oe_n,
    input wire logic pme_out,
    input wire logic pme_oe_n,
    input wire logic req_n,
    input wire logic req_oe_n,
    input wire logic ad_dev_oe_n,
    input wire logic ctl_oe_n,
    input wire logic addr_ph_n,
    input wire logic wr_n
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    // ========
    // Assertions
    // Two cycles: device sees the registered link reset one edge late
    a_reset_pins_float: assert property (!rst_n [*2] |-> inta_oe_n && pme_oe_n && req_oe_n && ad_dev_oe_n && ctl_oe_n)
        else $error("pin driven in link reset");
    a_od_pull_low: assert property ((!inta_oe_n |-> !inta_out) and (!pme_oe_n |-> !pme_out))
        else $error("open drain drives high");
    a_grant_follows_req: assert property ($fell(gnt_n) |-> $past(!req_n))
        else $error("grant without request");
    a_req_held: assert property (!req_n && gnt_n && rst_n |=> !req_n)
        else $error("request dropped before grant");
    a_addr_granted: assert property (!addr_ph_n |-> $past(!gnt_n) && !ad_dev_oe_n && req_n)
        else $error("address phase not owned");
    a_addr_one_cycle: assert property (!addr_ph_n |=> addr_ph_n)
        else $error("address phase too long");
    a_read_turn: assert property (!addr_ph_n && wr_n |=> ad_dev_oe_n && !ad_host_oe_n)
        else $error("read data phase wrong driver");
    a_write_data: assert property (!addr_ph_n && !wr_n |=> !ad_dev_oe_n)
        else $error("write data not driven");
    a_one_driver: assert property (ad_dev_oe_n || ad_host_oe_n)
        else $error("shared lines driven twice");
    c_write: cover property (!addr_ph_n && !wr_n);
    c_read: cover property (!addr_ph_n && wr_n);
    c_pme: cover property (!pme_oe_n);
    c_irq: cover property (!inta_oe_n);
endmodule // pbm_sva

// ---- sim/pbm_tb.sv ----
// Self-checking bench joining device and host ends
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module pbm_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ev = 8'h00, msk = 8'h00, clr = 8'h00, flags;
    logic [31:0] ctrl = 32'h0000_0000, xa = 32'h0000_0000, xd = 32'h0000_0000, hrd = 32'h0000_0000;
    logic magic = 1'b0, pclr = 1'b0, xreq = 1'b0, xwr = 1'b0, hreq = 1'b0, gen = 1'b1;
    logic pst, busy, done, lra, irq, pme, rds, wrs;
    logic [31:0] rdat, rda, wra, wrd, m_ra, m_wa, m_wd;
    int failures = 0;
    int total_checks = 0;

    pbm_if lnk();
    pbm_device #(.PME_PULSE_CYC(3)) pbm_device_inst (.SYS_CLK_I(clk), .RESET_I(rst), .bus(lnk),
        .EVENT_I(ev), .EVENT_MASK_I(msk), .EVENT_CLEAR_I(clr), .EVENT_FLAGS_O(flags),
        .POWER_WAKE_CONTROL_REGISTER_I(ctrl), .MAGIC_PKT_I(magic), .PME_STATUS_CLEAR_I(pclr),
        .PME_STATUS_O(pst), .XFER_REQ_I(xreq), .XFER_WRITE_I(xwr), .XFER_ADDR_I(xa),
        .XFER_WDATA_I(xd), .XFER_BUSY_O(busy), .XFER_DONE_O(done), .XFER_RDATA_O(rdat));
    // Short link reset keeps the run brief
    pbm_host #(.RST_HOLD_CYC(8)) pbm_host_inst (.SYS_CLK_I(clk), .RESET_I(rst), .bus(lnk),
        .HOST_RESET_REQ_I(hreq), .GRANT_ENABLE_I(gen), .HOST_RDATA_I(hrd), .LINK_RESET_ACTIVE_O(lra),
        .IRQ_O(irq), .PME_O(pme), .RD_STROBE_O(rds), .RD_ADDR_O(rda), .WR_STROBE_O(wrs),
        .WR_ADDR_O(wra), .WR_DATA_O(wrd));
    pbm_sva pbm_sva_inst (.SYS_CLK_I(clk), .RESET_I(rst), .rst_n(lnk.rst_n), .gnt_n(lnk.gnt_n),
        .ad_host_oe_n(lnk.ad_host_oe_n), .inta_out(lnk.inta_out), .inta_oe_n(lnk.inta_oe_n),
        .pme_out(lnk.pme_out), .pme_oe_n(lnk.pme_oe_n), .req_n(lnk.req_n), .req_oe_n(lnk.req_oe_n),
        .ad_dev_oe_n(lnk.ad_dev_oe_n), .ctl_oe_n(lnk.ctl_oe_n), .addr_ph_n(lnk.addr_ph_n),
        .wr_n(lnk.wr_n));

    // ========
    // Helpers
    initial begin
        forever #(pbm_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // Strobes last one cycle, so catch them mid-cycle
    always @(negedge clk) begin
        if (rds) m_ra <= rda;
        if (wrs) begin
            m_wa <= wra;
            m_wd <= wrd;
        end
    end
    task w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ========
    // Scenarios
    task t_reset;
        int n;
        n = 0;
        `CHK(lra, 1'b1)
        while (lra === 1'b1 && n < 40) begin
            `CHK({lnk.inta_n, lnk.pme_n, lnk.req_n, lnk.ad}, {3'h7, pbm_pkg::AD_IDLE})
            n++;
            w(1);
        end
        `CHK(n >= 8, 1'b1)
        `CHK(n < 40, 1'b1)
        $display("reset test done");
    endtask
    task t_irq;
        @(posedge clk) msk <= 8'h08;
        ev <= 8'h28;
        @(posedge clk) ev <= 8'h00;
        w(2);
        `CHK(lnk.inta_n, 1'b0)
        w(1);
        `CHK(irq, 1'b1)
        @(posedge clk) clr <= 8'h08;
        @(posedge clk) clr <= 8'h00;
        w(2);
        // Masked flag stays set but must not hold the pin
        `CHK({lnk.inta_n, flags}, {1'b1, 8'h20})
        $display("interrupt test done");
    endtask
    task t_link;
        int n;
        n = 0;
        @(posedge clk) ev <= 8'h01;
        msk <= 8'h01;
        hreq <= 1'b1;
        @(posedge clk) ev <= 8'h00;
        hreq <= 1'b0;
        w(4);
        `CHK({lnk.rst_n, lnk.inta_n, lnk.req_n}, 3'b011)
        while (lra === 1'b1 && n < 40) begin
            n++;
            w(1);
        end
        `CHK(n < 40, 1'b1)
        w(3);
        `CHK({lnk.inta_n, flags[0]}, 2'b01)
        @(posedge clk) clr <= 8'hFF;
        @(posedge clk) clr <= 8'h00;
        $display("link reset test done");
    endtask
    task t_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input bit stall);
        int n;
        logic dn;
        n = 0;
        dn = 1'b0;
        @(posedge clk) xreq <= 1'b1;
        xwr <= wr;
        xa <= a;
        xd <= d;
        hrd <= d;
        gen <= !stall;
        @(posedge clk) xreq <= 1'b0;
        if (stall) begin
            repeat (10) begin
                w(1);
                dn |= done;
            end
            `CHK({lnk.req_n, dn, busy}, 3'b001)
            @(posedge clk) gen <= 1'b1;
        end
        while (done !== 1'b1 && n < 50) begin
            w(1);
            n++;
        end
        `CHK(n < 50, 1'b1)
        w(1);
        if (wr) `CHK({m_wa, m_wd}, {a, d})
        else `CHK({m_ra, rdat}, {a, d})
        $display("transfer test done");
    endtask
    task t_wake(input logic en, input logic sel);
        int n;
        n = 0;
        @(posedge clk) ctrl <= {13'h0000, en, sel, 17'h0_0000};
        @(posedge clk) magic <= 1'b1;
        repeat (40) begin
            w(1);
            n += (lnk.pme_n === 1'b0);
        end
        `CHK(pst, en)
        `CHK({lnk.pme_n, pme}, {!(en && sel), en && sel})
        `CHK(n == 3, en && !sel)
        `CHK(n == 0, !en)
        @(posedge clk) pclr <= 1'b1;
        magic <= 1'b0;
        @(posedge clk) pclr <= 1'b0;
        w(3);
        `CHK({pst, lnk.pme_n}, 2'b01)
        $display("wake test done");
    endtask

    // ========
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        w(1);
        t_reset;
        t_irq;
        t_link;
        t_xfer(1'b1, 32'h0000_1000, 32'hA5A5_5A5A, 1'b0);
        t_xfer(1'b0, 32'h0000_2004, 32'h1234_5678, 1'b0);
        t_xfer(1'b1, 32'hFFFF_FFFC, 32'h0000_0000, 1'b1);
        t_xfer(1'b0, 32'h0000_0008, 32'h8000_0001, 1'b1);
        t_wake(1'b1, 1'b1);
        t_wake(1'b1, 1'b0);
        t_wake(1'b0, 1'b1);
        final_report;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        final_report;
    end
endmodule // pbm_tb
